// [rtl/prs_pkg.sv]
// constants and types for the position range output switch
// Contract
// RL1: a one-cycle enable pulse activates the switch; held enable refreshes status each scan
// RL2: servo, digitizing and time axes are all accepted as position source
// RL3: each table entry holds signed 32-bit on and off positions
// RL4: on<off: inside if pos>=on and pos<off; on>off: pos>=on or pos<off
// RL5: an entry with equal on and off is skipped
// RL6: output on when inside any valid range, off when inside none
// RL7: range count selects evaluated entries, valid 1 to 255
// RL8: rack variant accepts slot 0 or 3 to 13
// RL9: slot zero drives only the status output, no physical point
// RL10: program references at most two distinct slots in rack variant
// RL11: a 32-point module using both halves must be the only slot
// RL12: compact variant accepts slot 0 or 2 only
// RL13: pc-hosted analog variant accepts slot 0 through 8
// RL14: rack variant accepts point 1 to 32
// RL15: compact and pc-hosted variants accept point 1 to 16
// RL16: program never lets two axes drive the same point
// RL17: disable forces physical and status outputs off and stops control
// RL18: success flag cleared on bad axis, slot, point or too many slots
// RL19: outputs re-evaluated on every servo tick
// RL20: comparison works with or without position rollover
// RL21: while active, entries change only through the edit port
// RL22: edit port accepts index 0 to 254 and replaces that pair
// RL23: edit updates an on/off pair atomically
// RL24: signed 32-bit compares, all ranges evaluated within one servo tick
package prs_pkg;
  localparam int unsigned PRS_POS_W      = 32;
  localparam int unsigned PRS_DEPTH      = 255;
  localparam int unsigned PRS_IDX_W      = 8;
  localparam int unsigned PRS_AXIS_W     = 8;
  localparam int unsigned PRS_NUM_AXES   = 8;
  localparam logic [7:0]  PRS_QTY_MIN    = 8'h01;
  localparam logic [7:0]  PRS_QTY_MAX    = 8'hff;
  localparam logic [7:0]  PRS_IDX_MAX    = 8'hfe;
  localparam logic [7:0]  PRS_RACK_SMIN  = 8'h03;
  localparam logic [7:0]  PRS_RACK_SMAX  = 8'h0d;
  localparam logic [7:0]  PRS_CMPT_SLOT  = 8'h02;
  localparam logic [7:0]  PRS_PCA_SMAX   = 8'h08;
  localparam logic [7:0]  PRS_RACK_PMAX  = 8'h20;
  localparam logic [7:0]  PRS_SMALL_PMAX = 8'h10;
  localparam logic [7:0]  PRS_PNT_MIN    = 8'h01;
  localparam int unsigned PRS_NPTS       = 32;

  typedef enum logic [1:0] {
    PRS_VAR_RACK,
    PRS_VAR_COMPACT,
    PRS_VAR_PC_ANALOG
  } prs_variant_t;

  typedef enum logic [1:0] {
    PRS_AX_NONE,
    PRS_AX_SERVO,
    PRS_AX_DIGITIZING,
    PRS_AX_TIME
  } prs_axis_kind_t;
endpackage

// [rtl/prs_tbl_if.sv]
// table access bundle between the switch and its range table
`timescale 1ns/1ps
interface prs_tbl_if;
  import prs_pkg::*;
  logic                         wr_en;
  logic [PRS_IDX_W-1:0]         wr_idx;
  logic signed [PRS_POS_W-1:0]  wr_on;
  logic signed [PRS_POS_W-1:0]  wr_off;
  logic [PRS_IDX_W-1:0]         rd_idx;
  logic signed [PRS_POS_W-1:0]  rd_on;
  logic signed [PRS_POS_W-1:0]  rd_off;
  modport owner (output wr_en, wr_idx, wr_on, wr_off, rd_idx, input rd_on, rd_off);
  modport table_side (input wr_en, wr_idx, wr_on, wr_off, rd_idx, output rd_on, rd_off);
endinterface

// [rtl/prs_range_table.sv]
// range table memory: one on/off pair per word, written as a whole
`timescale 1ns/1ps
module prs_range_table
  import prs_pkg::*;
#(
  parameter int unsigned DEPTH = PRS_DEPTH
)(
  input  wire logic  i_clk,
  prs_tbl_if.table_side tbl
);
  // both halves in one word so a reader never sees a half-written entry
  logic [2*PRS_POS_W-1:0] mem [DEPTH]; // RL3

  always_ff @(posedge i_clk)
  begin
    if (tbl.wr_en && (32'(tbl.wr_idx) < DEPTH))
    begin
      mem[tbl.wr_idx] <= {tbl.wr_on, tbl.wr_off}; // RL23
    end
  end

  // combinational read keeps the scan at one entry per cycle
  assign tbl.rd_on  = (32'(tbl.rd_idx) < DEPTH) ? mem[tbl.rd_idx][2*PRS_POS_W-1:PRS_POS_W] : '0;
  assign tbl.rd_off = (32'(tbl.rd_idx) < DEPTH) ? mem[tbl.rd_idx][PRS_POS_W-1:0] : '0;
endmodule

// [rtl/prs_range_check.sv]
// single range membership test
`timescale 1ns/1ps
module prs_range_check
  import prs_pkg::*;
(
  input  wire logic signed [PRS_POS_W-1:0] i_pos,
  input  wire logic signed [PRS_POS_W-1:0] i_on,
  input  wire logic signed [PRS_POS_W-1:0] i_off,
  output logic                              o_inside
);
  // signed compares; rollover positions stay inside the same signed span
  always_comb
  begin
    if (i_on < i_off)
      o_inside = (i_pos >= i_on) && (i_pos < i_off);  // RL4 RL24
    else if (i_on > i_off)
      o_inside = (i_pos >= i_on) || (i_pos < i_off);  // RL4 RL20
    else
      o_inside = 1'b0;                                // RL5
  end
endmodule

// [rtl/prs_position_limit_switch.sv]
// position limit switch: range scan per servo tick, selection checks, edit port
`timescale 1ns/1ps
module prs_position_limit_switch
  import prs_pkg::*;
#(
  parameter prs_variant_t VARIANT  = PRS_VAR_RACK,
  parameter int unsigned  NUM_AXES = PRS_NUM_AXES
)(
  // clock and reset
  input  wire logic                             i_clk,
  input  wire logic                             i_rstn,
  // program call
  input  wire logic                             i_scan,
  input  wire logic                             i_enable,
  input  wire logic                             i_switch_disable,
  input  wire logic [PRS_AXIS_W-1:0]            i_axis,
  input  wire logic [7:0]                       i_range_count,
  input  wire logic [7:0]                       i_slot,
  input  wire logic [7:0]                       i_output_point,
  input  wire logic                             i_too_many_slots,
  output logic                                  o_ok,
  output logic                                  o_out,
  // axis position source
  input  wire logic                             i_servo_tick,
  input  wire logic [NUM_AXES*2-1:0]            i_axis_kind,
  input  wire logic [NUM_AXES*PRS_POS_W-1:0]    i_axis_pos,
  // direct table load, legal only while inactive
  input  wire logic                             i_load_en,
  input  wire logic [PRS_IDX_W-1:0]             i_load_idx,
  input  wire logic signed [PRS_POS_W-1:0]      i_load_on,
  input  wire logic signed [PRS_POS_W-1:0]      i_load_off,
  // range entry editor
  input  wire logic                             i_edit_en,
  input  wire logic [PRS_IDX_W-1:0]             i_entry_index,
  input  wire logic signed [PRS_POS_W-1:0]      i_edit_on,
  input  wire logic signed [PRS_POS_W-1:0]      i_edit_off,
  output logic                                  o_edit_ok,
  // discrete output module
  output logic [7:0]                            o_dout_slot,
  output logic [PRS_NPTS-1:0]                   o_dout_point,
  output logic [PRS_NPTS-1:0]                   o_dout_owned
);
  logic rst_s1_q;
  logic rst_n;

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      rst_s1_q <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_n    <= rst_s1_q;
    end
  end

  prs_tbl_if tbl ();

  prs_range_table #(.DEPTH(PRS_DEPTH)) u_table (
    .i_clk (i_clk),
    .tbl   (tbl)
  );

  // --- selection checks ---
  logic axis_ok;
  logic slot_ok;
  logic point_ok;
  logic count_ok;
  logic call_ok;
  logic [1:0] kind_sel;

  always_comb
  begin
    kind_sel = 2'b00;
    if (32'(i_axis) < NUM_AXES)
      kind_sel = i_axis_kind[i_axis*2 +: 2];
    // servo, digitizing and time axes are all acceptable sources
    axis_ok = (kind_sel != 2'(PRS_AX_NONE)); // RL2
  end

  always_comb
  begin
    case (VARIANT)
      PRS_VAR_RACK:
      begin
        slot_ok  = (i_slot == 8'h00) ||
                   ((i_slot >= PRS_RACK_SMIN) && (i_slot <= PRS_RACK_SMAX)); // RL8
        point_ok = (i_output_point >= PRS_PNT_MIN) &&
                   (i_output_point <= PRS_RACK_PMAX); // RL14
      end
      PRS_VAR_COMPACT:
      begin
        slot_ok  = (i_slot == 8'h00) || (i_slot == PRS_CMPT_SLOT); // RL12
        point_ok = (i_output_point >= PRS_PNT_MIN) &&
                   (i_output_point <= PRS_SMALL_PMAX); // RL15
      end
      PRS_VAR_PC_ANALOG:
      begin
        slot_ok  = (i_slot <= PRS_PCA_SMAX); // RL13
        point_ok = (i_output_point >= PRS_PNT_MIN) &&
                   (i_output_point <= PRS_SMALL_PMAX); // RL15
      end
      default:
      begin
        slot_ok  = 1'b0;
        point_ok = 1'b0;
      end
    endcase
    count_ok = (i_range_count >= PRS_QTY_MIN) && (i_range_count <= PRS_QTY_MAX); // RL7
  end

  // slot bookkeeping across instances is done outside; its verdict arrives here
  assign call_ok = axis_ok && slot_ok && point_ok && count_ok && !i_too_many_slots; // RL18 RL10

  // --- activation state, latched on a call ---
  logic                  active_q;
  logic [PRS_AXIS_W-1:0] axis_q;
  logic [7:0]            count_q;
  logic [7:0]            slot_q;
  logic [4:0]            pbit_q;

  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      active_q <= 1'b0;
    end
    else if (i_scan && i_switch_disable)
    begin
      active_q <= 1'b0; // RL17
    end
    else if (i_scan && i_enable && call_ok)
    begin
      // one enabled call is enough; the switch then stays active
      active_q <= 1'b1; // RL1
    end
  end

  // call settings, kept only from an accepted enabling call
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      axis_q  <= '0;
      count_q <= 8'h00;
      slot_q  <= 8'h00;
      pbit_q  <= 5'h00;
    end
    else if (i_scan && i_enable && !i_switch_disable && call_ok)
    begin
      axis_q  <= i_axis;
      count_q <= i_range_count;
      slot_q  <= i_slot;
      pbit_q  <= 5'(i_output_point - PRS_PNT_MIN);
    end
  end

  // --- scan engine: walks the first count_q entries once per servo tick ---
  typedef enum logic [1:0] {
    PRS_ST_IDLE,
    PRS_ST_SCAN,
    PRS_ST_DONE
  } prs_state_t;

  prs_state_t             state_q;
  logic [PRS_IDX_W-1:0]   idx_q;
  logic                   hit_q;
  logic                   result_q;
  logic [7:0]             scan_cnt_q;
  logic signed [PRS_POS_W-1:0] pos_q;
  logic                   entry_in;

  prs_range_check u_check (
    .i_pos    (pos_q),
    .i_on     (tbl.rd_on),
    .i_off    (tbl.rd_off),
    .o_inside (entry_in)
  );

  // position is sampled at the tick, so one scan compares one snapshot
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q  <= PRS_ST_IDLE;
      idx_q    <= '0;
      hit_q    <= 1'b0;
      scan_cnt_q <= 8'h00;
      pos_q    <= '0;
    end
    else
    begin
      case (state_q)
        PRS_ST_IDLE:
        begin
          if (i_servo_tick && active_q) // RL19
          begin
            state_q <= PRS_ST_SCAN;
            idx_q   <= '0;
            hit_q   <= 1'b0;
            pos_q   <= i_axis_pos[axis_q*PRS_POS_W +: PRS_POS_W];
            // count frozen at the tick; a call mid-scan cannot strand the index
            scan_cnt_q <= count_q;
          end
        end
        PRS_ST_SCAN:
        begin
          hit_q <= hit_q | entry_in; // RL6
          if (idx_q == scan_cnt_q - 8'h01)
            state_q <= PRS_ST_DONE;
          else
            idx_q <= idx_q + 8'h01;
        end
        PRS_ST_DONE:
        begin
          state_q <= PRS_ST_IDLE;
        end
        default:
        begin
          state_q <= PRS_ST_IDLE;
        end
      endcase
    end
  end

  assign tbl.rd_idx = idx_q;

  // a stale result must not reappear when the switch is enabled again
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      result_q <= 1'b0;
    end
    else if (!active_q)
    begin
      result_q <= 1'b0;
    end
    else if (state_q == PRS_ST_DONE)
    begin
      // all ranges done before the output moves; 255 entries fit a tick
      result_q <= hit_q; // RL24
    end
  end

  // --- table writes: editor has priority over direct load ---
  logic edit_ok;
  assign edit_ok = i_edit_en && (i_entry_index <= PRS_IDX_MAX); // RL22

  always_comb
  begin
    // direct loads are ignored while active so the scan is not disturbed
    if (edit_ok)
    begin
      tbl.wr_en  = 1'b1; // RL23
      tbl.wr_idx = i_entry_index;
      tbl.wr_on  = i_edit_on;
      tbl.wr_off = i_edit_off;
    end
    else
    begin
      tbl.wr_en  = i_load_en && !active_q; // RL21
      tbl.wr_idx = i_load_idx;
      tbl.wr_on  = i_load_on;
      tbl.wr_off = i_load_off;
    end
  end

  // --- registered outputs ---
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_ok <= 1'b0;
    end
    else if (i_scan)
    begin
      o_ok <= call_ok; // RL18
    end
  end

  // answers one cycle after the request and stands for that cycle only
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_edit_ok <= 1'b0;
    end
    else
    begin
      o_edit_ok <= edit_ok; // RL22
    end
  end

  // a disabling call clears o_out and the point outputs on its own edge, not one later; o_dout_slot holds
  logic drive_off;
  assign drive_off = !active_q || (i_scan && i_switch_disable); // RL17

  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_out <= 1'b0;
    end
    else if (drive_off)
    begin
      o_out <= 1'b0; // RL17
    end
    else
    begin
      o_out <= result_q; // RL6
    end
  end

  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_dout_slot <= 8'h00;
    end
    else if (!drive_off)
    begin
      o_dout_slot <= slot_q;
    end
  end

  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_dout_point <= '0;
      o_dout_owned <= '0;
    end
    else if (drive_off || (slot_q == 8'h00)) // RL9 RL17
    begin
      // slot zero touches no physical point
      o_dout_point <= '0;
      o_dout_owned <= '0;
    end
    else
    begin
      o_dout_point <= PRS_NPTS'(result_q) << pbit_q;
      o_dout_owned <= PRS_NPTS'(1) << pbit_q;
    end
  end
endmodule

// [test/prs_axis_source.sv]
// axis position source model: axis kinds, positions and servo ticks
`timescale 1ns/1ps
module prs_axis_source
  import prs_pkg::*;
#(
  parameter int unsigned GAP = 300
)(
  // clock and reset
  input  wire logic                          i_clk,
  input  wire logic                          i_rstn,
  // position of axis 0
  input  wire logic signed [PRS_POS_W-1:0]   i_pos,
  // to the switch
  output logic                               o_tick,
  output logic [PRS_NUM_AXES*2-1:0]          o_kind,
  output logic [PRS_NUM_AXES*PRS_POS_W-1:0]  o_pos
);
  logic [15:0] cnt_q;
  // axis k sits k units ahead, so a wrong axis pick shows
  always_comb
  begin
    o_kind = {8'h55, 2'h0, 2'h3, 2'h2, 2'h1};
    for (int k = 0; k < PRS_NUM_AXES; k++)
      o_pos[k*PRS_POS_W +: PRS_POS_W] = i_pos + k;
  end
  // ticks spaced wider than the longest scan
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      cnt_q  <= 16'h0000;
      o_tick <= 1'b0;
    end
    else
    begin
      cnt_q  <= (cnt_q == 16'(GAP - 1)) ? 16'h0000 : cnt_q + 16'h0001;
      o_tick <= (cnt_q == 16'(GAP - 1));
    end
  end
endmodule

// [test/prs_plsw_monitor.sv]
// port assertions for the position limit switch
`timescale 1ns/1ps
module prs_plsw_monitor
  import prs_pkg::*;
#(
  parameter prs_variant_t VARIANT = PRS_VAR_RACK
)(
  input  wire logic                 i_clk,
  input  wire logic                 i_rstn,
  input  wire logic                 i_scan,
  input  wire logic                 i_switch_disable,
  input  wire logic [7:0]           i_range_count,
  input  wire logic [7:0]           i_slot,
  input  wire logic [7:0]           i_output_point,
  input  wire logic                 i_too_many_slots,
  input  wire logic                 i_servo_tick,
  input  wire logic                 i_edit_en,
  input  wire logic [PRS_IDX_W-1:0] i_entry_index,
  input  wire logic                 o_ok,
  input  wire logic                 o_out,
  input  wire logic                 o_edit_ok,
  input  wire logic [7:0]           o_dout_slot,
  input  wire logic [PRS_NPTS-1:0]  o_dout_point,
  input  wire logic [PRS_NPTS-1:0]  o_dout_owned
);
  logic [8:0] since_tick_q;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      since_tick_q <= 9'h000;
    else if (i_servo_tick)
      since_tick_q <= 9'h000;
    else if (since_tick_q != 9'h1ff)
      since_tick_q <= since_tick_q + 9'h001;
  end
  sequence off_call_s;
    i_scan && i_switch_disable;
  endsequence
  sequence quiet_s;
    (!i_scan)[*8];
  endsequence
  disable_clears_a: assert property (off_call_s |=> !o_out && o_dout_point == 32'h0)
    else $error("disable left an output on");
  disabled_holds_a: assert property (off_call_s ##1 quiet_s |-> !o_out)
    else $error("output came back while disabled");
  bad_call_a: assert property (VARIANT == PRS_VAR_RACK && i_scan
    && (i_range_count == 8'h00 || i_too_many_slots
    || i_output_point == 8'h00 || i_output_point > 8'h20 || i_slot == 8'h01
    || i_slot == 8'h02 || i_slot > 8'h0d) |=> !o_ok)
    else $error("bad call reported success");
  ok_stands_a: assert property (!i_scan |=> $stable(o_ok))
    else $error("success flag moved without a call");
  edit_answer_a: assert property (i_edit_en |=> o_edit_ok == ($past(i_entry_index) <= 8'hfe))
    else $error("edit answer wrong");
  rise_after_tick_a: assert property ($rose(o_out) |-> since_tick_q <= 9'h104)
    else $error("output rose far from a tick");
  point_mirror_a: assert property (o_dout_owned != 32'h0 |->
    ((o_dout_point & o_dout_owned) != 32'h0) == o_out)
    else $error("physical point disagrees with status");
  slot_zero_a: assert property (o_dout_point != 32'h0 |-> o_dout_slot != 8'h00)
    else $error("point driven with slot zero");
endmodule
bind prs_position_limit_switch prs_plsw_monitor #(.VARIANT(VARIANT)) u_prs_plsw_monitor (
  .i_clk(i_clk), .i_rstn(i_rstn), .i_scan(i_scan), .i_switch_disable(i_switch_disable),
  .i_range_count(i_range_count), .i_slot(i_slot), .i_output_point(i_output_point),
  .i_too_many_slots(i_too_many_slots), .i_servo_tick(i_servo_tick), .i_edit_en(i_edit_en),
  .i_entry_index(i_entry_index), .o_ok(o_ok), .o_out(o_out), .o_edit_ok(o_edit_ok),
  .o_dout_slot(o_dout_slot), .o_dout_point(o_dout_point), .o_dout_owned(o_dout_owned));

// [test/test_prs_position_limit_switch.sv]
// self-checking bench for the position limit switch
`timescale 1ns/1ps
module test_prs_position_limit_switch;
  logic               clk, rstn, scan, en, dis, tms, load_en, edit_en, active;
  logic               ok, out, edit_ok, tick, ok_c, ok_p;
  logic [7:0]         axis, cnt, slot, output_point, load_idx, edit_idx, dslot;
  logic signed [31:0] load_on, load_off, edit_on, edit_off, pos, v;
  logic [31:0]        dpoint, downed;
  logic [15:0]        kind;
  logic [255:0]       apos;
  logic signed [31:0] t_on [8];
  logic signed [31:0] t_off [8];
  logic [7:0]         cur_axis, cur_cnt, cur_slot, cur_pnt;
  logic [39:0]        bad [9];
  int                 fails, tests_run, seed;

  prs_axis_source u_prs_axis_source (.i_clk(clk), .i_rstn(rstn), .i_pos(pos), .o_tick(tick),
    .o_kind(kind), .o_pos(apos));
  prs_position_limit_switch u_prs_position_limit_switch (.i_clk(clk), .i_rstn(rstn),
    .i_scan(scan), .i_enable(en), .i_switch_disable(dis), .i_axis(axis), .i_range_count(cnt),
    .i_slot(slot), .i_output_point(output_point), .i_too_many_slots(tms), .o_ok(ok), .o_out(out),
    .i_servo_tick(tick), .i_axis_kind(kind), .i_axis_pos(apos), .i_load_en(load_en),
    .i_load_idx(load_idx), .i_load_on(load_on), .i_load_off(load_off), .i_edit_en(edit_en),
    .i_entry_index(edit_idx), .i_edit_on(edit_on), .i_edit_off(edit_off), .o_edit_ok(edit_ok),
    .o_dout_slot(dslot), .o_dout_point(dpoint), .o_dout_owned(downed));
  // the other two variants share all inputs; only their call answer is compared
  prs_position_limit_switch #(.VARIANT(prs_pkg::PRS_VAR_COMPACT))
    u_prs_position_limit_switch_cmp (.i_clk(clk), .i_rstn(rstn), .i_scan(scan), .i_enable(en),
    .i_switch_disable(dis), .i_axis(axis), .i_range_count(cnt), .i_slot(slot),
    .i_output_point(output_point), .i_too_many_slots(tms), .o_ok(ok_c), .o_out(), .i_servo_tick(tick),
    .i_axis_kind(kind), .i_axis_pos(apos), .i_load_en(load_en), .i_load_idx(load_idx),
    .i_load_on(load_on), .i_load_off(load_off), .i_edit_en(edit_en), .i_entry_index(edit_idx),
    .i_edit_on(edit_on), .i_edit_off(edit_off), .o_edit_ok(), .o_dout_slot(),
    .o_dout_point(), .o_dout_owned());
  prs_position_limit_switch #(.VARIANT(prs_pkg::PRS_VAR_PC_ANALOG))
    u_prs_position_limit_switch_pca (.i_clk(clk), .i_rstn(rstn), .i_scan(scan), .i_enable(en),
    .i_switch_disable(dis), .i_axis(axis), .i_range_count(cnt), .i_slot(slot),
    .i_output_point(output_point), .i_too_many_slots(tms), .o_ok(ok_p), .o_out(), .i_servo_tick(tick),
    .i_axis_kind(kind), .i_axis_pos(apos), .i_load_en(load_en), .i_load_idx(load_idx),
    .i_load_on(load_on), .i_load_off(load_off), .i_edit_en(edit_en), .i_entry_index(edit_idx),
    .i_edit_on(edit_on), .i_edit_off(edit_off), .o_edit_ok(), .o_dout_slot(),
    .o_dout_point(), .o_dout_owned());

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  function automatic logic hit(input logic signed [31:0] p, input int n);
    logic h;
    h = 1'b0;
    for (int i = 0; i < n; i++)
      if (t_on[i] < t_off[i]) h |= p >= t_on[i] && p < t_off[i];
      else if (t_on[i] > t_off[i]) h |= p >= t_on[i] || p < t_off[i];
    return h;
  endfunction

  // v: 0 rack, 1 compact, 2 pc-hosted analog
  function automatic logic ok_exp(input int v, input logic [7:0] a, c, s, p, input logic t);
    logic s_ok;
    s_ok = (v == 0) ? (s == 8'h00 || (s >= 8'h03 && s <= 8'h0d))
      : (v == 1) ? (s == 8'h00 || s == 8'h02) : (s <= 8'h08);
    return a < 8'h08 && a != 8'h03 && c != 8'h00 && s_ok && p >= 8'h01
      && p <= ((v == 0) ? 8'h20 : 8'h10) && !t;
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic call(input logic e, d, input logic [7:0] a, c, s, p, input logic t);
    @(posedge clk);
    {scan, en, dis, axis, cnt, slot, output_point, tms} <= {1'b1, e, d, a, c, s, p, t};
    @(posedge clk);
    scan <= 1'b0;
    if (d)
      active = 1'b0;
    else if (e && ok_exp(0, a, c, s, p, t))
    begin
      active = 1'b1;
      {cur_axis, cur_cnt, cur_slot, cur_pnt} = {a, c, s, p};
    end
    @(posedge clk);
    #1 chk("ok", ok, ok_exp(0, a, c, s, p, t));
    chk("ok compact", ok_c, ok_exp(1, a, c, s, p, t));
    chk("ok pc analog", ok_p, ok_exp(2, a, c, s, p, t));
  endtask

  // ed selects the editor, otherwise the inactive-only direct load
  task automatic put(input logic ed, input logic [7:0] i, input logic signed [31:0] a, b);
    @(posedge clk);
    if (ed) {edit_en, edit_idx, edit_on, edit_off} <= {1'b1, i, a, b};
    else {load_en, load_idx, load_on, load_off} <= {1'b1, i, a, b};
    @(posedge clk);
    {edit_en, load_en} <= 2'b00;
    if (i < 8'h08) {t_on[i[2:0]], t_off[i[2:0]]} = {a, b};
    #1 if (ed) chk("edit_ok", edit_ok, i <= 8'hfe);
  endtask

  task automatic look(input logic signed [31:0] w);
    logic e;
    logic [31:0] m;
    @(posedge clk);
    pos <= w - cur_axis;
    @(posedge clk iff tick);
    repeat (cur_cnt + 4) @(posedge clk);
    #1 e = active && hit(w, cur_cnt);
    chk("out", out, e);
    chk("point", dpoint[cur_pnt-1], cur_slot != 8'h00 && e);
    if (active) chk("slot", dslot, cur_slot);
    m = (active && cur_slot != 8'h00) ? 32'h1 << (cur_pnt - 8'h01) : 32'h0;
    chk("owned", downed, m);
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    #160000;
    fails++;
    stop_test;
  end

  initial
  begin
    {scan, en, dis, axis, cnt, slot, output_point, tms, load_en, load_idx, load_on, load_off} = '0;
    {edit_en, edit_idx, edit_on, edit_off, pos, active, cur_axis, cur_pnt} = '0;
    cur_cnt = 8'h01;
    cur_pnt = 8'h01;
    cur_slot = 8'h00;
    seed = 32'h3f5e4be2;
    bad = '{40'h0308030500, 40'h0808030500, 40'h0000030500, 40'h0008010500, 40'h0008020500,
            40'h00080e0500, 40'h0008030000, 40'h0008032100, 40'h0008030501};
    rstn = 1'b0;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    put(1'b0, 8'h00, -32'sd100, 32'sd100);
    put(1'b0, 8'h01, 32'sd500, -32'sd500);
    put(1'b0, 8'h02, 32'sd50, 32'sd50);
    put(1'b0, 8'h03, 32'sh7fffff00, 32'sh80000100);
    for (int i = 4; i < 8; i++) put(1'b0, 8'(i), $random(seed) % 800, $random(seed) % 800);
    foreach (bad[i]) call(1'b1, 1'b0, bad[i][39:32], bad[i][31:24], bad[i][23:16],
      bad[i][15:8], bad[i][0]);
    look(32'sd0);
    for (int a = 0; a < 3; a++)
    begin
      call(1'b1, 1'b0, 8'(a), 8'(1 + ($random(seed) & 7)), (a == 2) ? 8'h00 : 8'(3 + 10 * a),
        8'(1 + ($random(seed) & 31)), 1'b0);
      for (int j = 0; j < 7; j++)
      begin
        v = (j == 0) ? t_on[0] : (j == 1) ? t_off[0] : (j == 2) ? t_on[1] : (j == 3)
          ? 32'sh7ffffff0 : $random(seed) % 1000;
        look(v);
      end
    end
    call(1'b1, 1'b0, 8'h00, 8'h08, 8'h03, 8'h20, 1'b0);
    put(1'b1, 8'h02, 32'sd900, 32'sd950);
    look(32'sd920);
    put(1'b1, 8'hff, 32'sd0, 32'sd1);
    look(32'sd920);
    call(1'b1, 1'b1, 8'h00, 8'h08, 8'h03, 8'h20, 1'b0);
    look(32'sd920);
    chk("all points", dpoint, 32'h0);
    call(1'b1, 1'b0, 8'h00, 8'h08, 8'h03, 8'h20, 1'b0);
    look(32'sd920);
    look(32'sd0);
    stop_test;
  end
endmodule
